// ==== rtl/mpr_pkg.sv ====
/*
  constants, types and helper functions for the mesh packet router
  assumes one clock domain; packets are 72 bits: payload [71:40], key [39:8], control [7:0]
*/
// Functional notes
// - six bidirectional neighbour links plus local ports
// - multicast by table, point-to-point by address, neighbour separate
// - failed or congested link detoured via triangle
// - every detour use reported to monitor
// - router never stalls its current output packet
// - outputs show capacity before a packet is sent
// - blocked multicast or point-to-point output tries detour path instead of waiting
// - detour also blocked drops packet to monitor
// - two-bit stamp, phase runs 00 01 11 10
// - stamp xor phase equal 11 drops with error
// - phase length set at run time, conservatively long
// - point-to-point to this node goes to monitor
// - fixed unique node address steers point-to-point routing
// - multicast detour bits: normal, both, detour, returning
// - router stamps launch phase into local packets other than neighbour class
// - class 00 multicast, 01 point, 10 neighbour
// - packet carries odd parity, payload counted only when present
package mpr_pkg;
  localparam int NLINK = 6;
  localparam int NPROC = 20;
  localparam int NENT = 1024;
  localparam int PKW = 72;
  localparam int RTW = NLINK + NPROC;
  // control byte fields and packet field positions
  localparam int PAR_BIT = 0;
  localparam int DATA_BIT = 1;
  localparam int TS_LO = 2;
  localparam int RT_LO = 2;
  localparam int EM_LO = 4;
  localparam int CLS_LO = 6;
  localparam int KEY_LO = 8;
  localparam int DST_LO = 24;
  localparam int PAY_LO = 40;
  // packet classes
  localparam logic [1:0] multicast_class = 2'h0;
  localparam logic [1:0] point_to_point_class = 2'h1;
  localparam logic [1:0] neighbour_class = 2'h2;
  // multicast detour status codes
  localparam logic [1:0] EM_NORMAL = 2'h0;
  localparam logic [1:0] EM_BOTH = 2'h1;
  localparam logic [1:0] EM_DET_ONLY = 2'h2;
  localparam logic [1:0] EM_RETURN = 2'h3;
  // neighbour route field codes and arrival port of local traffic
  localparam logic [2:0] NB_ALL = 3'h6;
  localparam logic [2:0] NB_MON = 3'h7;
  localparam logic [2:0] PORT_LOCAL = 3'h7;
  localparam logic [1:0] TS_OLD = 2'h3;
  localparam logic [5:0] ALL_LINKS = 6'h3F;
  // monitor packet reasons
  localparam logic [1:0] RSN_DROP = 2'h0;
  localparam logic [1:0] RSN_OLD = 2'h1;
  localparam logic [1:0] RSN_ERR = 2'h2;
  localparam logic [1:0] RSN_PASS = 2'h3;

  typedef enum logic [1:0] {MON_IDLE = 2'b01, MON_BUSY = 2'b10} mpr_mon_t;

  // xor over the packet; 1 means odd parity, payload counted only when present
  function automatic logic mpr_odd(input logic [PKW-1:0] p);
    logic [PKW-1:0] m;
    m = p;
    if (!p[DATA_BIT])
      m[PKW-1:PAY_LO] = '0;
    return ^m;
  endfunction

  // rewrite the parity bit so the packet is odd
  function automatic logic [PKW-1:0] mpr_par_fix(input logic [PKW-1:0] p);
    logic [PKW-1:0] q;
    q = p;
    q[PAR_BIT] = 1'b0;
    q[PAR_BIT] = ~mpr_odd(q);
    return q;
  endfunction

  function automatic logic [5:0] mpr_port_mask(input logic [2:0] port);
    logic [5:0] m;
    m = '0;
    if (port < 3'h6)
      m[port] = 1'b1;
    return m;
  endfunction

  // link l to l+1, link l to l-1, link l to the opposite link
  function automatic logic [5:0] mpr_rot1(input logic [5:0] m);
    return {m[4:0], m[5]};
  endfunction

  function automatic logic [5:0] mpr_rotb(input logic [5:0] m);
    return {m[0], m[5:1]};
  endfunction

  function automatic logic [5:0] mpr_rot3(input logic [5:0] m);
    return {m[2:0], m[5:3]};
  endfunction

  // hex step toward dst; links 0 E, 1 NE, 2 N, 3 W, 4 SW, 5 S
  function automatic logic [5:0] mpr_hex_dir(input logic [15:0] dst, input logic [15:0] here);
    logic signed [8:0] dx;
    logic signed [8:0] dy;
    logic [5:0] m;
    dx = $signed({1'b0, dst[15:8]}) - $signed({1'b0, here[15:8]});
    dy = $signed({1'b0, dst[7:0]}) - $signed({1'b0, here[7:0]});
    if (dx > 0 && dy > 0)
      m = 6'h02;
    else if (dx < 0 && dy < 0)
      m = 6'h10;
    else if (dx > 0)
      m = 6'h01;
    else if (dx < 0)
      m = 6'h08;
    else if (dy > 0)
      m = 6'h04;
    else
      m = 6'h20;
    return m;
  endfunction
endpackage

// ==== rtl/mpr_mc_table.sv ====
/*
  associative multicast routing table: key, mask and route per entry
  assumes writes come from configuration logic on the same clock
*/
`timescale 1ns/1ps
module mpr_key_table
  import mpr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // entry write
  input wire logic wr_en,
  input wire logic [9:0] wr_idx,
  input wire logic [31:0] wr_key,
  input wire logic [31:0] wr_mask,
  input wire logic [RTW-1:0] wr_route,
  // lookup
  input wire logic [31:0] lk_key,
  output logic lk_hit,
  output logic [RTW-1:0] lk_route
);
  logic [31:0] key_m [NENT];
  logic [31:0] mask_m [NENT];
  logic [RTW-1:0] route_m [NENT];
  logic [NENT-1:0] vld_r;
  logic [NENT-1:0] vld_nxt;

  ////////////////////////////////////////////////////////////////////////
  // entry valid bits follow writes
  always_comb
  begin
    vld_nxt = vld_r;
    if (wr_en)
      vld_nxt[wr_idx] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      vld_r <= '0;
    else
      vld_r <= vld_nxt;
  end

  // table contents need no reset, valid bits guard them
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      key_m[wr_idx] <= wr_key;
      mask_m[wr_idx] <= wr_mask;
      route_m[wr_idx] <= wr_route;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // masked match, lowest index wins
  always_comb
  begin
    lk_hit = 1'b0;
    lk_route = '0;
    for (int i = NENT - 1; i >= 0; i--)
    begin
      if (vld_r[i] && (((lk_key ^ key_m[i]) & mask_m[i]) == 32'h0000_0000))
      begin
        lk_hit = 1'b1;
        lk_route = route_m[i];
      end
    end
  end
endmodule

// ==== rtl/mpr_router.sv ====
/*
  per-node packet router: one packet per cycle in, copies to six links,
  local processors and the monitor; detours around blocked links
  assumes link capacity and failure levels come from same-clock link logic
*/
`timescale 1ns/1ps
module mpr_router
  import mpr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // packet input from the arbiter
  input wire logic in_valid,
  input wire logic [2:0] in_port,
  input wire logic [PKW-1:0] in_pkt,
  output logic in_ready,
  // neighbour links
  input wire logic [NLINK-1:0] link_ready,
  input wire logic [NLINK-1:0] link_fail,
  output logic [NLINK-1:0] link_valid,
  output logic [NLINK-1:0][PKW-1:0] link_pkt,
  // local processors
  input wire logic local_ready,
  output logic local_valid,
  output logic [NPROC-1:0] local_mask,
  output logic [PKW-1:0] local_pkt,
  // monitor processor
  input wire logic [4:0] mon_id,
  input wire logic mon_ready,
  output logic mon_valid,
  output logic [PKW-1:0] mon_pkt,
  output logic [1:0] mon_reason,
  output logic [NLINK-1:0] detour_evt,
  output logic err_evt,
  // node identity, time phase, table writes
  input wire logic [15:0] node_addr,
  input wire logic [1:0] phase,
  input wire logic tbl_we,
  input wire logic [9:0] tbl_idx,
  input wire logic [31:0] tbl_key,
  input wire logic [31:0] tbl_mask,
  input wire logic [RTW-1:0] tbl_route
);
  logic [1:0] rst_s_r;
  logic rst_n;
  logic [15:0] node_s_r;
  logic [15:0] node_r;
  logic [1:0] phase_r;
  logic key_hit;
  logic [RTW-1:0] key_route;
  logic acc, from_loc, old, bad, err, to_mon;
  logic [1:0] cls, em, reason;
  logic [5:0] want, fwd, ok, blk, det, lost, go;
  logic [NPROC-1:0] procs;
  logic [PKW-1:0] base;
  logic in_ready_r, in_ready_nxt;
  logic [NLINK-1:0] link_valid_r, link_valid_nxt, detour_r, detour_nxt;
  logic [NLINK-1:0][PKW-1:0] link_pkt_r, link_pkt_nxt;
  logic local_valid_r, local_valid_nxt;
  logic [NPROC-1:0] local_mask_r, local_mask_nxt;
  logic [PKW-1:0] local_pkt_r, local_pkt_nxt, mon_pkt_r, mon_pkt_nxt;
  logic mon_valid_r, mon_valid_nxt, err_r, err_nxt;
  logic [1:0] mon_reason_r, mon_reason_nxt;
  mpr_mon_t st_r, st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_s_r <= 2'h0;
    else
      rst_s_r <= {rst_s_r[0], 1'b1};
  end
  assign rst_n = rst_s_r[1];

  // node address pins pass two flops; phase from on-chip driver taken once
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      node_s_r <= 16'h0000;
      node_r <= 16'h0000;
      phase_r <= 2'h0; // any phase pace is accepted
    end
    else
    begin
      node_s_r <= node_addr;
      node_r <= node_s_r;
      phase_r <= phase;
    end
  end

  mpr_key_table u_table (
    .clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(tbl_we),
    .wr_idx(tbl_idx),
    .wr_key(tbl_key),
    .wr_mask(tbl_mask),
    .wr_route(tbl_route),
    .lk_key(in_pkt[KEY_LO+:32]),
    .lk_hit(key_hit),
    .lk_route(key_route)
  );

  ////////////////////////////////////////////////////////////////////////
  // route decision for the packet taken this cycle
  always_comb
  begin
    acc = in_valid && in_ready_r;
    cls = in_pkt[CLS_LO+:2];
    em = in_pkt[EM_LO+:2];
    from_loc = (in_port == PORT_LOCAL);
    old = !from_loc && ((in_pkt[TS_LO+:2] ^ phase_r) == TS_OLD);
    bad = !mpr_odd(in_pkt);
    want = '0;
    fwd = '0;
    procs = '0;
    to_mon = 1'b0;
    err = 1'b0;
    reason = RSN_DROP;
    case (cls)
      multicast_class:
      begin
        // detoured copy finishes its triangle on the link after arrival
        if (!from_loc && (em == EM_BOTH || em == EM_DET_ONLY))
          fwd = mpr_rot1(mpr_port_mask(in_port));
        if (from_loc || em != EM_DET_ONLY)
        begin
          if (key_hit)
            {procs, want} = key_route;
          else if (from_loc)
            to_mon = 1'b1;
          else
            want = mpr_rot3(mpr_port_mask(in_port)); // straight through on a miss
        end
      end
      point_to_point_class:
      begin
        if (in_pkt[DST_LO+:16] == node_r)
          procs[mon_id] = 1'b1;
        else
          want = mpr_hex_dir(in_pkt[DST_LO+:16], node_r);
      end
      neighbour_class:
      begin
        if (!from_loc || in_pkt[RT_LO+:3] == NB_MON)
        begin
          to_mon = 1'b1;
          reason = RSN_PASS;
        end
        else if (in_pkt[RT_LO+:3] == NB_ALL)
          want = ALL_LINKS;
        else
          want = mpr_port_mask(in_pkt[RT_LO+:3]);
      end
      default:
      begin
        to_mon = 1'b1;
        err = 1'b1;
        reason = RSN_ERR;
      end
    endcase
    if (bad || old)
    begin
      want = '0;
      fwd = '0;
      procs = '0;
      to_mon = 1'b1;
      err = 1'b1;
      reason = old ? RSN_OLD : RSN_ERR;
    end
    // capacity is known before sending, so blocked links never wait
    ok = link_ready & ~link_fail;
    blk = want & ~ok;
    det = '0;
    if (cls == multicast_class || cls == point_to_point_class)
      det = mpr_rot1(blk) & ok & ~fwd;
    lost = (blk & ~mpr_rotb(det)) | (fwd & ~ok);
    go = (want & ok) | det | (fwd & ok);
    if (|lost || (|procs && !local_ready) || (go == 6'h00 && procs == '0))
      to_mon = 1'b1;
    // launch phase stamped by this router, neighbour route bits untouched
    base = in_pkt;
    if (from_loc && cls != neighbour_class)
      base[TS_LO+:2] = phase_r;
  end

  // per-link copies carry fresh parity; multicast copies also carry their own detour status
  for (genvar i = 0; i < NLINK; i++)
  begin : g_link
    always_comb
    begin
      link_pkt_nxt[i] = base;
      if (cls == multicast_class)
      begin
        if (fwd[i])
          link_pkt_nxt[i][EM_LO+:2] = EM_RETURN;
        else if (det[i] && want[i] && ok[i])
          link_pkt_nxt[i][EM_LO+:2] = EM_BOTH;
        else if (det[i])
          link_pkt_nxt[i][EM_LO+:2] = EM_DET_ONLY;
        else
          link_pkt_nxt[i][EM_LO+:2] = EM_NORMAL;
      end
      link_pkt_nxt[i] = mpr_par_fix(link_pkt_nxt[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next output values; a monitor packet pauses input until it is taken
  always_comb
  begin
    link_valid_nxt = acc ? go : '0;
    detour_nxt = acc ? (blk & mpr_rotb(det)) : '0;
    local_valid_nxt = acc && |procs && local_ready;
    local_mask_nxt = procs;
    local_pkt_nxt = mpr_par_fix(base);
    err_nxt = acc && err;
    st_nxt = st_r;
    mon_valid_nxt = mon_valid_r;
    mon_pkt_nxt = mon_pkt_r;
    mon_reason_nxt = mon_reason_r;
    case (st_r)
      MON_IDLE:
      begin
        if (acc && to_mon)
        begin
          st_nxt = MON_BUSY;
          mon_valid_nxt = 1'b1;
          mon_pkt_nxt = in_pkt;
          mon_reason_nxt = reason;
        end
      end
      MON_BUSY:
      begin
        if (mon_ready)
        begin
          st_nxt = MON_IDLE;
          mon_valid_nxt = 1'b0;
        end
      end
      default:
      begin
        st_nxt = MON_IDLE;
        mon_valid_nxt = 1'b0;
      end
    endcase
    in_ready_nxt = (st_nxt == MON_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= MON_IDLE;
      in_ready_r <= 1'b0;
      link_valid_r <= '0;
      link_pkt_r <= '0;
      detour_r <= '0;
      local_valid_r <= 1'b0;
      local_mask_r <= '0;
      local_pkt_r <= '0;
      mon_valid_r <= 1'b0;
      mon_pkt_r <= '0;
      mon_reason_r <= 2'h0;
      err_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      in_ready_r <= in_ready_nxt;
      link_valid_r <= link_valid_nxt;
      link_pkt_r <= link_pkt_nxt;
      detour_r <= detour_nxt;
      local_valid_r <= local_valid_nxt;
      local_mask_r <= local_mask_nxt;
      local_pkt_r <= local_pkt_nxt;
      mon_valid_r <= mon_valid_nxt;
      mon_pkt_r <= mon_pkt_nxt;
      mon_reason_r <= mon_reason_nxt;
      err_r <= err_nxt;
    end
  end

  // outputs straight from flops
  assign in_ready = in_ready_r;
  assign link_valid = link_valid_r;
  assign link_pkt = link_pkt_r;
  assign detour_evt = detour_r;
  assign local_valid = local_valid_r;
  assign local_mask = local_mask_r;
  assign local_pkt = local_pkt_r;
  assign mon_valid = mon_valid_r;
  assign mon_pkt = mon_pkt_r;
  assign mon_reason = mon_reason_r;
  assign err_evt = err_r;

  ////////////////////////////////////////////////////////////////////////
  // checks on the router's own outputs
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_capacity_honour: assert property ((link_valid_r & ~$past(link_ready)) == 6'h00)
    else $error("link sent without capacity");
  a_fail_avoided: assert property ((link_valid_r & $past(link_fail)) == 6'h00)
    else $error("packet sent on failed link");
  a_detour_notice: assert property ((mpr_rot1(detour_r) & ~link_valid_r) == 6'h00)
    else $error("detour reported without detour copy");
  a_old_trap: assert property (acc && old |=> mon_valid_r && err_r && link_valid_r == 6'h00
    && mon_reason_r == RSN_OLD)
    else $error("aged packet not trapped");
  a_never_stuck: assert property (acc |=> (|link_valid_r) || local_valid_r || mon_valid_r)
    else $error("accepted packet left by no path");
  a_link_parity: assert property (link_valid_r[0] |-> mpr_odd(link_pkt_r[0]))
    else $error("link packet parity not odd");
  a_stamp_phase: assert property (acc && from_loc && cls == multicast_class ##1 link_valid_r[0]
    |-> link_pkt_r[0][TS_LO+:2] == $past(phase_r))
    else $error("launch stamp differs from phase");
  a_mon_hold: assert property (mon_valid_r && !mon_ready |=> mon_valid_r && $stable(mon_pkt_r))
    else $error("monitor packet lost before taken");
  a_reserved_drop: assert property (acc && cls == 2'h3 |=> mon_valid_r && err_r)
    else $error("reserved class not dropped");
  a_self_deliver: assert property (acc && cls == point_to_point_class && !bad
    && in_pkt[DST_LO+:16] == node_r |=> local_valid_r || mon_valid_r)
    else $error("packet for this node not delivered locally");

  c_detour: cover property (|detour_r);
  c_old_drop: cover property (err_r && mon_reason_r == RSN_OLD);
  c_fanout: cover property ($countones(link_valid_r) > 1);
  c_mon_wait: cover property (mon_valid_r && !mon_ready ##1 mon_ready);
endmodule

// ==== testbench/mpr_far_side.sv ====
/*
  far side model: six neighbour links, local processors and the monitor
  assumes the router clock; controls change just after the rising edge
*/
`timescale 1ns/1ps
module mpr_far_side
  import mpr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // scenario controls
  input wire logic [NLINK-1:0] blk,
  input wire logic [NLINK-1:0] dead,
  input wire logic [3:0] mon_wait,
  input wire logic lbusy,
  // router side
  input wire logic [NLINK-1:0] link_valid,
  input wire logic mon_valid,
  output logic [NLINK-1:0] link_ready,
  output logic [NLINK-1:0] link_fail,
  output logic local_ready,
  output logic mon_ready,
  output logic [7:0] bad_cnt
);
  logic [3:0] cnt_r;
  logic [NLINK-1:0] rdy_r;

  // capacity and failure shown as levels before any send
  assign link_ready = ~blk;
  assign link_fail = dead;
  assign local_ready = ~lbusy;

  ////////////////////////////////////////////////////////////////////
  // count cycles with a copy pushed into a link that had no room; monitor
  // accepts every drop after mon_wait + 1 cycles, never refuses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 4'h0;
      mon_ready <= 1'b0;
      rdy_r <= '0;
      bad_cnt <= 8'h00;
    end
    else
    begin
      rdy_r <= link_ready;
      if ((link_valid & ~rdy_r) != '0)
        bad_cnt <= bad_cnt + 8'h01;
      if (!mon_valid || mon_ready)
      begin
        cnt_r <= 4'h0;
        mon_ready <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_r + 4'h1;
        mon_ready <= (cnt_r == mon_wait);
      end
    end
  end
endmodule

// ==== testbench/tb_mesh_packet_router.sv ====
/*
  self-checking bench for the mesh packet router
  assumes the far side model and a 20 MHz clock
*/
`timescale 1ns/1ps
module tb_mesh_packet_router
  import mpr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic in_valid = 1'b0;
  logic [2:0] in_port = 3'h7;
  logic [PKW-1:0] in_pkt = '0;
  logic in_ready, local_ready, local_valid, mon_ready, mon_valid, err_evt;
  logic [NLINK-1:0] link_ready, link_fail, link_valid, detour_evt;
  logic [NLINK-1:0][PKW-1:0] link_pkt;
  logic [NPROC-1:0] local_mask;
  logic [PKW-1:0] local_pkt, mon_pkt;
  logic [1:0] mon_reason;
  logic [4:0] mon_id = 5'h03;
  logic [15:0] node_addr = 16'h8080;
  logic [1:0] phase = 2'h1;
  logic tbl_we = 1'b0;
  logic [9:0] tbl_idx = 10'h000;
  logic [31:0] tbl_key = 32'h0, tbl_mask = 32'h0;
  logic [RTW-1:0] tbl_route = '0;
  logic [NLINK-1:0] blk = '0, dead = '0;
  logic [3:0] mon_wait = 4'h2;
  logic lbusy = 1'b0;
  logic [7:0] bad_cnt;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  mpr_router dut (.ref_clk, .arst_n, .in_valid, .in_port, .in_pkt, .in_ready,
    .link_ready, .link_fail, .link_valid, .link_pkt, .local_ready, .local_valid,
    .local_mask, .local_pkt, .mon_id, .mon_ready, .mon_valid, .mon_pkt, .mon_reason,
    .detour_evt, .err_evt, .node_addr, .phase, .tbl_we, .tbl_idx, .tbl_key,
    .tbl_mask, .tbl_route);
  mpr_far_side far (.clk(ref_clk), .rst_n(arst_n), .blk, .dead, .mon_wait, .lbusy,
    .link_valid, .mon_valid, .link_ready, .link_fail, .local_ready, .mon_ready,
    .bad_cnt);

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  // odd-parity packet with payload; mid is control bits 5:2
  function automatic logic [PKW-1:0] mk(input logic [1:0] cls, input logic [3:0] mid,
    input logic [31:0] key);
    logic [PKW-1:0] p;
    p = {32'hA5A50F0F, key, cls, mid, 1'b1, 1'b0};
    p[0] = ~(^p);
    return p;
  endfunction

  task automatic check(input string what, input logic [PKW-1:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // offer one packet, held until taken; returns in the answer cycle
  // an idle edge first keeps back-to-back calls from toggling in_valid at once
  task automatic send(input logic [2:0] p, input logic [PKW-1:0] k);
    int n;
    n = 0;
    @(posedge ref_clk);
    #2;
    while (in_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    if (in_ready !== 1'b1)
      failures++;
    in_valid = 1'b1;
    in_port = p;
    in_pkt = k;
    @(posedge ref_clk);
    #2;
    in_valid = 1'b0;
  endtask

  task automatic wait_mon();
    int n;
    n = 0;
    while (mon_valid !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    if (mon_valid !== 1'b0)
      failures++;
  endtask

  ////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_unicast();
    logic [15:0] d [6];
    d = '{16'h9080, 16'h9090, 16'h8090, 16'h7080, 16'h7070, 16'h8070};
    for (int i = 0; i < 6; i++)
    begin
      send(3'h7, mk(2'h1, 4'h0, {d[i], 16'h1234}));
      check("unicast link_valid", link_valid, 6'h01 << i);
      check("unicast link_pkt", link_pkt[i], mk(2'h1, {2'h0, phase}, {d[i], 16'h1234}));
    end
    send(3'h7, mk(2'h1, 4'h0, {node_addr, 16'h0}));
    check("own node local_valid", local_valid, 1'b1);
    check("own node local_mask", local_mask, 20'h1 << mon_id);
    check("own node local_pkt", local_pkt, mk(2'h1, {2'h0, phase}, {node_addr, 16'h0}));
    lbusy = 1'b1;
    send(3'h7, mk(2'h1, 4'h0, {node_addr, 16'h0}));
    check("busy local_valid", local_valid, 1'b0);
    check("busy mon_reason", mon_reason, RSN_DROP);
    lbusy = 1'b0;
    wait_mon();
  endtask

  task automatic t_detour();
    for (int m = 0; m < 2; m++)
    begin
      blk = (m == 0) ? 6'h01 : 6'h00;
      dead = (m == 1) ? 6'h01 : 6'h00;
      send(3'h7, mk(2'h1, 4'h0, {16'h9080, 16'h0}));
      check("detour link_valid", link_valid, 6'h02);
      check("detour link_pkt", link_pkt[1], mk(2'h1, {2'h0, phase}, {16'h9080, 16'h0}));
      check("detour_evt", detour_evt, 6'h01);
    end
    blk = 6'h03;
    dead = 6'h00;
    mon_wait = 4'h5;
    send(3'h7, mk(2'h1, 4'h0, {16'h9080, 16'h0}));
    check("drop link_valid", link_valid, 6'h00);
    check("drop mon_reason", mon_reason, RSN_DROP);
    check("drop mon_pkt", mon_pkt, mk(2'h1, 4'h0, {16'h9080, 16'h0}));
    repeat (4)
    begin
      check("drop mon_valid held", mon_valid, 1'b1);
      check("drop in_ready", in_ready, 1'b0);
      @(posedge ref_clk);
      #2;
    end
    blk = 6'h00;
    wait_mon();
    mon_wait = 4'h2;
  endtask

  task automatic t_age();
    logic [1:0] g [4];
    g = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int i = 0; i < 4; i++)
    begin
      phase = g[i];
      repeat (3) @(posedge ref_clk);
      #2;
      send(3'h2, mk(2'h1, {2'h0, g[i] ^ 2'h3}, {16'h9080, 16'h0}));
      check("aged mon_reason", mon_reason, RSN_OLD);
      check("aged err_evt", err_evt, 1'b1);
      check("aged link_valid", link_valid, 6'h00);
      wait_mon();
    end
    send(3'h2, mk(2'h1, 4'h3, {16'h9080, 16'h0}));
    check("young link_valid", link_valid, 6'h01);
    phase = 2'h1;
    repeat (3) @(posedge ref_clk);
    #2;
  endtask

  task automatic t_err();
    send(3'h7, mk(2'h3, 4'h0, 32'h0));
    check("reserved mon_reason", mon_reason, RSN_ERR);
    check("reserved err_evt", err_evt, 1'b1);
    wait_mon();
    send(3'h7, mk(2'h1, 4'h0, {16'h9080, 16'h0}) ^ 72'h1);
    check("parity mon_reason", mon_reason, RSN_ERR);
    check("parity err_evt", err_evt, 1'b1);
    wait_mon();
  endtask

  task automatic t_multicast();
    tbl_we = 1'b1;
    tbl_key = 32'h12345678;
    tbl_mask = 32'hFFFFFFFF;
    tbl_route = 26'h1;
    @(posedge ref_clk);
    #2;
    tbl_we = 1'b0;
    send(3'h7, mk(2'h0, 4'h0, 32'h12345678));
    check("multicast link_pkt", link_pkt[0], mk(2'h0, {2'h0, phase}, 32'h12345678));
    check("multicast link_valid", link_valid, 6'h01);
    blk = 6'h01;
    send(3'h7, mk(2'h0, 4'h0, 32'h12345678));
    check("multicast detour pkt", link_pkt[1], mk(2'h0, {2'h2, phase}, 32'h12345678));
    check("multicast detour_evt", detour_evt, 6'h01);
    blk = 6'h00;
    send(3'h2, mk(2'h0, 4'h0, 32'h0BAD0000));
    check("multicast miss link_valid", link_valid, 6'h20);
  endtask

  task automatic t_neighbour();
    send(3'h7, mk(2'h2, 4'h6, 32'h0));
    check("neighbour all link_valid", link_valid, 6'h3F);
    check("neighbour link_pkt", link_pkt[3], mk(2'h2, 4'h6, 32'h0));
    send(3'h4, mk(2'h2, 4'h0, 32'h0));
    check("neighbour in mon_reason", mon_reason, RSN_PASS);
    wait_mon();
  endtask

  task automatic test_done();
    $display("failures %0d checks %0d", failures, num_checks);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #2;
    arst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2;
    t_unicast();
    t_detour();
    t_age();
    t_err();
    t_multicast();
    t_neighbour();
    check("sends into full link", bad_cnt, 8'h00);
    test_done();
  end
endmodule
